// ### common/pwm_timer_params.svh
// Register map, field positions, reset values and counting constants
`ifndef PWM_TIMER_PARAMS_SVH
`define PWM_TIMER_PARAMS_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_COUNT 8'h04
`define REG_CMP_A 8'h08
`define REG_CMP_B 8'h0C
`define REG_CAPT 8'h10
`define REG_FLAGS 8'h14
`define REG_ACT_A 8'h18
`define REG_ACT_B 8'h1C

// Control register fields
`define CTRL_WGM_LSB 0
`define CTRL_OSEL_A_LSB 4
`define CTRL_OSEL_B_LSB 6
`define CTRL_CS_LSB 8
`define CTRL_DIR_A_BIT 11
`define CTRL_DIR_B_BIT 12
`define CTRL_W 13

// Flag register bits
`define FLAG_OVF_BIT 0
`define FLAG_CMP_A_BIT 1
`define FLAG_CMP_B_BIT 2
`define FLAG_CAPT_BIT 3

// Reset values
`define CTRL_RST 13'h0000
`define VAL16_RST 16'h0000
`define FLAGS_RST 4'h0

// Waveform generation modes served here
`define WGM_PC_8BIT 4'h1
`define WGM_PC_9BIT 4'h2
`define WGM_PC_10BIT 4'h3
`define WGM_PFC_CAPT 4'h8
`define WGM_PFC_CMPA 4'h9
`define WGM_PC_CAPT 4'hA
`define WGM_PC_CMPA 4'hB

// Fixed TOP values and counter ends
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define BOTTOM 16'h0000

// Compare output select encodings
`define OSEL_NONINV 2'h2
`define OSEL_INV 2'h3

// Prescaler select codes and divider masks
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define PRESC_W 10
`define MASK_DIV8 10'h007
`define MASK_DIV64 10'h03F
`define MASK_DIV256 10'h0FF
`define MASK_DIV1024 10'h3FF

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### common/pwm_timer_pkg.sv
// Types shared by the dual-slope PWM timer and its prescaler
`include "pwm_timer_params.svh"

package pwm_timer_pkg;

  // Counting direction
  typedef enum logic
  {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;

  // AXI4-Lite master to slave
  typedef struct packed
  {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  // AXI4-Lite slave to master
  typedef struct packed
  {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  // Compare output pins, value and output enable per channel
  typedef struct packed
  {
    logic [1:0] level;
    logic [1:0] oe;
  } pwm_pins_t;

  // Prescaler state
  typedef struct packed
  {
    logic [`PRESC_W-1:0] div;
  } presc_state_t;

  // Whole timer state
  typedef struct packed
  {
    logic [15:0] cnt;
    dir_t dir;
    logic [1:0][15:0] cmp_buf;
    logic [1:0][15:0] cmp_act;
    logic [15:0] capt;
    logic [`CTRL_W-1:0] ctrl;
    logic [3:0] flags;
    logic [1:0] lvl;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } timer_state_t;

endpackage : pwm_timer_pkg

// ### src/dual_slope_pwm_timer16.sv
// Dual-slope 16-bit PWM timer with an AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_params.svh"

module dual_slope_pwm_timer16
(
  input wire logic clk,
  input wire logic nrst,
  input wire pwm_timer_pkg::axil_req_t axil_req,
  output pwm_timer_pkg::axil_rsp_t axil_rsp,
  output pwm_timer_pkg::pwm_pins_t pwm_pins,
  output logic [15:0] count_value,
  output logic [3:0] event_flags
);
  import pwm_timer_pkg::*;

  timer_state_t st;
  timer_state_t next_st;
  logic timer_tick_enable;
  logic [3:0] wgm;
  logic pc_mode;
  logic pfc_mode;
  logic fixed_top;
  logic top_from_cmpa;
  logic [15:0] top;
  logic [15:0] next_cnt;
  logic at_top;
  logic at_bottom;
  logic do_write;
  logic do_read;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;

  // Merge write data into an old value under the byte strobes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Fixed TOP for the resolution modes, zero for the others
  function automatic logic [15:0] fixed_top_of(input logic [3:0] mode);
    logic [15:0] res;
    res = `BOTTOM;
    unique case (mode)
      `WGM_PC_8BIT: res = `TOP_8BIT;
      `WGM_PC_9BIT: res = `TOP_9BIT;
      `WGM_PC_10BIT: res = `TOP_10BIT;
      default: res = `BOTTOM;
    endcase
    return res;
  endfunction : fixed_top_of

  // Tick enable only; the counter never sees a derived clock
  timer_prescaler #(
    .DIV_W(`PRESC_W)
  ) u_prescaler (
    .clk(clk),
    .nrst(nrst),
    .clock_select(st.ctrl[`CTRL_CS_LSB +: 3]),
    .timer_tick_enable(timer_tick_enable)
  );

  // Mode decode and TOP source
  always_comb
  begin
    wgm = st.ctrl[`CTRL_WGM_LSB +: 4];
    pc_mode = (wgm == `WGM_PC_8BIT) || (wgm == `WGM_PC_9BIT) ||
              (wgm == `WGM_PC_10BIT) || (wgm == `WGM_PC_CAPT) ||
              (wgm == `WGM_PC_CMPA);
    pfc_mode = (wgm == `WGM_PFC_CAPT) || (wgm == `WGM_PFC_CMPA);
    fixed_top = fixed_top_of(wgm) != `BOTTOM;
    top_from_cmpa = (wgm == `WGM_PC_CMPA) || (wgm == `WGM_PFC_CMPA);
    if (fixed_top)
    begin
      top = fixed_top_of(wgm);
    end
    else if (top_from_cmpa)
    begin
      top = st.cmp_act[0];
    end
    else
    begin
      // Capture value is used live, so a lowered TOP may be missed
      top = st.capt;
    end
  end

  // Next counter value; ends are each held for one tick
  always_comb
  begin
    next_cnt = st.cnt;
    if (st.dir == DIR_UP)
    begin
      next_cnt = (st.cnt == top) ? st.cnt - 1'b1 : st.cnt + 1'b1;
    end
    else
    begin
      next_cnt = (st.cnt == `BOTTOM) ? st.cnt + 1'b1 : st.cnt - 1'b1;
    end
    at_top = timer_tick_enable && (pc_mode || pfc_mode) &&
             st.dir == DIR_UP && next_cnt == top;
    at_bottom = timer_tick_enable && (pc_mode || pfc_mode) &&
                st.dir == DIR_DOWN && next_cnt == `BOTTOM;
  end

  // Bus handshake conditions
  always_comb
  begin
    do_write = st.aw_held && st.w_held && !st.bvalid;
    do_read = axil_req.arvalid && !st.rvalid;
  end

  // Whole next-state computation
  always_comb
  begin
    logic [31:0] wval;
    logic [15:0] cmp_masked;
    logic [1:0] osel;
    logic match;
    logic lvl_base;
    next_st = st;
    wval = '0;
    cmp_masked = '0;
    osel = '0;
    match = 1'b0;
    lvl_base = 1'b0;
    flag_set = '0;
    flag_clr = '0;

    // Counter and direction move only on a timer tick
    if (timer_tick_enable && (pc_mode || pfc_mode))
    begin
      next_st.cnt = next_cnt;
      if (st.dir == DIR_UP && st.cnt == top)
      begin
        next_st.dir = DIR_DOWN;
      end
      else if (st.dir == DIR_DOWN && st.cnt == `BOTTOM)
      begin
        next_st.dir = DIR_UP;
      end
    end

    // Buffered compares load at TOP or BOTTOM by mode
    if ((pc_mode && at_top) || (pfc_mode && at_bottom))
    begin
      next_st.cmp_act = st.cmp_buf;
    end
    else if (!pc_mode && !pfc_mode)
    begin
      next_st.cmp_act = st.cmp_buf;
    end

    // Event flags
    if (at_bottom)
    begin
      flag_set[`FLAG_OVF_BIT] = 1'b1;
    end
    if (at_top && !fixed_top)
    begin
      if (top_from_cmpa)
      begin
        flag_set[`FLAG_CMP_A_BIT] = 1'b1;
      end
      else
      begin
        flag_set[`FLAG_CAPT_BIT] = 1'b1;
      end
    end

    // Compare channels; a match acts in the direction of the slope
    for (int i = 0; i < 2; i++)
    begin
      osel = st.ctrl[`CTRL_OSEL_A_LSB + 2*i +: 2];
      match = timer_tick_enable && st.cnt == st.cmp_act[i];
      if (match)
      begin
        flag_set[`FLAG_CMP_A_BIT + i] = 1'b1;
      end
      if (pc_mode || pfc_mode)
      begin
        // Work on the plain level, so an inverted pin holds between matches
        lvl_base = st.lvl[i] ^ (osel == `OSEL_INV);
        if (st.cmp_act[i] == `BOTTOM)
        begin
          lvl_base = 1'b0;
        end
        else if (st.cmp_act[i] >= top)
        begin
          lvl_base = 1'b1;
        end
        else if (match)
        begin
          lvl_base = (st.dir == DIR_DOWN);
        end
        if (osel == `OSEL_INV)
        begin
          next_st.lvl[i] = ~lvl_base;
        end
        else if (osel == `OSEL_NONINV)
        begin
          next_st.lvl[i] = lvl_base;
        end
        else
        begin
          next_st.lvl[i] = 1'b0;
        end
      end
    end

    // Write address and data are taken in either order
    if (axil_req.awvalid && !st.aw_held && !st.bvalid)
    begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = axil_req.awaddr;
    end
    if (axil_req.wvalid && !st.w_held && !st.bvalid)
    begin
      next_st.w_held = 1'b1;
      next_st.wdata = axil_req.wdata;
      next_st.wstrb = axil_req.wstrb;
    end

    // Register write once both halves are held
    if (do_write)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `RESP_OKAY;
      unique case ({st.awaddr[7:2], 2'b00})
        `REG_CTRL:
        begin
          wval = merge_bytes({19'h0, st.ctrl}, st.wdata, st.wstrb);
          next_st.ctrl = wval[`CTRL_W-1:0];
        end
        `REG_COUNT:
        begin
          // Software write to the counter wins over a tick
          wval = merge_bytes({16'h0, st.cnt}, st.wdata, st.wstrb);
          next_st.cnt = wval[15:0];
        end
        `REG_CMP_A, `REG_CMP_B:
        begin
          wval = merge_bytes({16'h0, st.cmp_buf[st.awaddr[2]]},
                             st.wdata, st.wstrb);
          cmp_masked = fixed_top ? (wval[15:0] & top) : wval[15:0];
          next_st.cmp_buf[st.awaddr[2]] = cmp_masked;
        end
        `REG_CAPT:
        begin
          wval = merge_bytes({16'h0, st.capt}, st.wdata, st.wstrb);
          next_st.capt = wval[15:0];
        end
        `REG_FLAGS:
        begin
          if (st.wstrb[0])
          begin
            flag_clr = st.wdata[3:0];
          end
        end
        `REG_ACT_A, `REG_ACT_B:
        begin
          next_st.bresp = `RESP_OKAY;
        end
        default:
        begin
          next_st.bresp = `RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && axil_req.bready)
    begin
      next_st.bvalid = 1'b0;
    end

    // Sticky flags: write one to clear, a new event wins
    next_st.flags = (st.flags & ~flag_clr) | flag_set;

    // Read data is latched when the address is taken
    if (do_read)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RESP_OKAY;
      unique case ({axil_req.araddr[7:2], 2'b00})
        `REG_CTRL: next_st.rdata = {19'h0, st.ctrl};
        `REG_COUNT: next_st.rdata = {16'h0, st.cnt};
        `REG_CMP_A: next_st.rdata = {16'h0, st.cmp_buf[0]};
        `REG_CMP_B: next_st.rdata = {16'h0, st.cmp_buf[1]};
        `REG_CAPT: next_st.rdata = {16'h0, st.capt};
        `REG_FLAGS: next_st.rdata = {27'h0, st.dir, st.flags};
        `REG_ACT_A: next_st.rdata = {16'h0, st.cmp_act[0]};
        `REG_ACT_B: next_st.rdata = {16'h0, st.cmp_act[1]};
        default:
        begin
          next_st.rdata = 32'h00000000;
          next_st.rresp = `RESP_SLVERR;
        end
      endcase
    end
    else if (st.rvalid && axil_req.rready)
    begin
      next_st.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.cnt <= `VAL16_RST;
      st.dir <= DIR_UP;
      st.ctrl <= `CTRL_RST;
      st.flags <= `FLAGS_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Bus answers; ready terms are combinational from held state
  always_comb
  begin
    axil_rsp.awready = !st.aw_held && !st.bvalid;
    axil_rsp.wready = !st.w_held && !st.bvalid;
    axil_rsp.bvalid = st.bvalid;
    axil_rsp.bresp = st.bresp;
    axil_rsp.arready = !st.rvalid;
    axil_rsp.rvalid = st.rvalid;
    axil_rsp.rdata = st.rdata;
    axil_rsp.rresp = st.rresp;
  end

  // Pins: the level shows only with direction set and PWM selected
  always_comb
  begin
    pwm_pins.level = st.lvl;
    pwm_pins.oe[0] = st.ctrl[`CTRL_DIR_A_BIT] &&
                     st.ctrl[`CTRL_OSEL_A_LSB + 1];
    pwm_pins.oe[1] = st.ctrl[`CTRL_DIR_B_BIT] &&
                     st.ctrl[`CTRL_OSEL_B_LSB + 1];
    count_value = st.cnt;
    event_flags = st.flags;
  end

endmodule : dual_slope_pwm_timer16
`default_nettype wire

// ### src/timer_prescaler.sv
// Prescaler making the timer tick enable from the I/O clock
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_params.svh"

module timer_prescaler
#(
  parameter int DIV_W = `PRESC_W
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] clock_select,
  output logic timer_tick_enable
);
  import pwm_timer_pkg::*;

  presc_state_t st;
  presc_state_t next_st;

  // The divider masks need exactly this width
  if (DIV_W != `PRESC_W)
  begin : g_bad_width
    $error("timer_prescaler: DIV_W must equal the divider mask width");
  end

  // Free-running divider; a stopped clock select freezes it at zero
  always_comb
  begin
    next_st = st;
    if (clock_select == `CS_STOP)
    begin
      next_st.div = '0;
    end
    else
    begin
      next_st.div = st.div + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // One-cycle enable when the masked divider bits are all ones
  always_comb
  begin
    unique case (clock_select)
      `CS_DIV1: timer_tick_enable = 1'b1;
      `CS_DIV8: timer_tick_enable = (st.div & `MASK_DIV8) == `MASK_DIV8;
      `CS_DIV64: timer_tick_enable = (st.div & `MASK_DIV64) == `MASK_DIV64;
      `CS_DIV256: timer_tick_enable = (st.div & `MASK_DIV256) == `MASK_DIV256;
      `CS_DIV1024:
        timer_tick_enable = (st.div & `MASK_DIV1024) == `MASK_DIV1024;
      default: timer_tick_enable = 1'b0;
    endcase
  end

endmodule : timer_prescaler
`default_nettype wire

// ### tb/dual_slope_pwm_timer16_assertions.sv
// Port checker for the dual-slope PWM timer
`timescale 1ns/1ps
`default_nettype none

module timer_checker
(
  input wire logic clk,
  input wire logic nrst,
  input wire pwm_timer_pkg::axil_req_t axil_req,
  input wire pwm_timer_pkg::axil_rsp_t axil_rsp,
  input wire pwm_timer_pkg::pwm_pins_t pwm_pins,
  input wire logic [15:0] count_value,
  input wire logic [3:0] event_flags
);
  import pwm_timer_pkg::*;
  logic [2:0] wr_hist;
  logic quiet;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Recent writes, so a software load is not taken for counting
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_hist <= 3'h0;
    end
    else
    begin
      wr_hist <= {wr_hist[1:0], axil_req.wvalid};
    end
  end
  assign quiet = !axil_req.wvalid && wr_hist == 3'h0;

  property p_step;
    quiet && $changed(count_value) |->
      count_value == $past(count_value) + 16'h0001 ||
      count_value == $past(count_value) - 16'h0001;
  endproperty
  a_step: assert property (p_step)
    else $error("Counter jumped");

  property p_ovf;
    quiet && $rose(event_flags[0]) |->
      count_value == 16'h0000 && $past(count_value) == 16'h0001;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("Overflow off bottom");

  property p_top_flag;
    quiet && $rose(event_flags[3]) |->
      count_value == $past(count_value) + 16'h0001;
  endproperty
  a_top_flag: assert property (p_top_flag)
    else $error("Top flag");

  property p_oe;
    $changed(pwm_pins.oe) |-> wr_hist != 3'h0;
  endproperty
  a_oe: assert property (p_oe) else $error("Enable moved alone");

  property p_rlat;
    axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("Read late");

  property p_wlat;
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid &&
      axil_rsp.wready |-> ##[1:2] axil_rsp.bvalid;
  endproperty
  a_wlat: assert property (p_wlat) else $error("Write late");

  // Read slot frees once the answer is taken
  property p_rfree;
    axil_rsp.rvalid && axil_req.rready |=> axil_rsp.arready;
  endproperty
  a_rfree: assert property (p_rfree) else $error("Read slot stuck");

  property p_bclear;
    axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid;
  endproperty
  a_bclear: assert property (p_bclear) else $error("Response stuck");

  cover property ($rose(event_flags[0]));
  cover property ($rose(event_flags[3]));
  cover property ($rose(pwm_pins.level[0]));
endmodule : timer_checker

bind dual_slope_pwm_timer16 timer_checker chk_u
(
  .clk(clk),
  .nrst(nrst),
  .axil_req(axil_req),
  .axil_rsp(axil_rsp),
  .pwm_pins(pwm_pins),
  .count_value(count_value),
  .event_flags(event_flags)
);

`default_nettype wire

// ### tb/dual_slope_pwm_timer16_tb.sv
// Self-checking bench for the dual-slope PWM timer
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_params.svh"

module dual_slope_pwm_timer16_tb;
  import pwm_timer_pkg::*;
  typedef struct packed
  {
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0] resp;
  } exp_t;
  logic clk;
  logic nrst;
  axil_req_t req;
  axil_rsp_t rsp;
  pwm_pins_t pins;
  logic [15:0] cnt;
  logic [3:0] flags;
  logic pin_a;
  logic pin_b;
  logic [15:0] prev_cnt;
  logic [15:0] rnd;
  exp_t exp_q[$];
  exp_t seen;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  dual_slope_pwm_timer16 dut_u (.clk(clk), .nrst(nrst), .axil_req(req),
    .axil_rsp(rsp), .pwm_pins(pins), .count_value(cnt), .event_flags(flags));
  pin_load load_u (.pins(pins), .pin_a(pin_a), .pin_b(pin_b));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [31:0] cw(input logic [3:0] m,
    input logic [1:0] sa, input logic [1:0] sb, input logic [2:0] cs,
    input logic da);
    cw = {19'h0, 1'b0, da, cs, sb, sa, m};
  endfunction : cw

  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic check(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // Write: both halves offered at once, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    logic aw = 1'b1;
    logic w = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge clk);
      if (rsp.awready === 1'b1) aw = 1'b0;
      if (rsp.wready === 1'b1) w = 1'b0;
      req.awvalid <= aw;
      req.wvalid <= w;
    end
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    check("bresp", {30'h0, r}, {30'h0, rsp.bresp});
    req.bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Read: the expectation is queued, the monitor compares the answer
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic [1:0] r);
    exp_q.push_back(exp_t'{d, m, r});
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  // One whole period from one entry into bottom to the next
  task automatic measure(input logic [15:0] top, output int per,
    output int at_top, output int hi_a, output int hi_b);
    int k = 0;
    per = 0;
    at_top = 0;
    hi_a = 0;
    hi_b = 0;
    while (k < 2)
    begin
      @(posedge clk);
      if (cnt === 16'h0000 && prev_cnt !== 16'h0000) k++;
      if (k == 1)
      begin
        per++;
        if (cnt === top) at_top++;
        if (pin_a === 1'b1) hi_a++;
        if (pins.level[1] === 1'b1) hi_b++;
      end
    end
  endtask : measure

  // Answer monitor takes the oldest expectation
  always @(posedge clk)
  begin
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1 && exp_q.size() > 0)
    begin
      seen = exp_q.pop_front();
      check("rdata", seen.data, rsp.rdata & seen.mask);
      check("rresp", {30'h0, seen.resp}, {30'h0, rsp.rresp});
    end
  end

  // Cycle budget cuts a hung handshake or a stalled counter short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    prev_cnt <= cnt;
    if (cycles == 60000)
    begin
      miscompares++;
      end_sim();
    end
  end

  initial
  begin
    logic [3:0] modes [7];
    int divs [5];
    logic [15:0] top;
    logic [15:0] c;
    int per;
    int at_top;
    int hi_a;
    int hi_b;
    modes = '{`WGM_PC_8BIT, `WGM_PC_9BIT, `WGM_PC_10BIT, `WGM_PC_CAPT,
      `WGM_PC_CMPA, `WGM_PFC_CAPT, `WGM_PFC_CMPA};
    divs = '{1, 8, 64, 256, 1024};
    rnd = 16'h01DD;
    nrst = 1'b0;
    req = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(`REG_CTRL, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
    rd(`REG_FLAGS, 32'h0, 32'hFFFFFFFF, `RESP_OKAY);
    rd(8'h20, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
    wr(8'h24, 32'h1, `RESP_SLVERR);
    // Every dual-slope mode, fixed and register TOP
    for (int i = 0; i < 7; i++)
    begin
      rnd = lfsr(rnd);
      top = 16'h0003 + {12'h000, rnd[3:0]};
      wr(`REG_CTRL, 32'h0, `RESP_OKAY);
      wr(`REG_CMP_A, {16'h0, top}, `RESP_OKAY);
      wr(`REG_CAPT, {16'h0, top}, `RESP_OKAY);
      wr(`REG_COUNT, 32'h0, `RESP_OKAY);
      wr(`REG_CTRL, cw(modes[i], 2'h0, 2'h0, `CS_DIV1, 1'b0), `RESP_OKAY);
      if (i < 3)
      begin
        top = (i == 0) ? `TOP_8BIT : (i == 1) ? `TOP_9BIT : `TOP_10BIT;
        wr(`REG_CMP_A, 32'h0000FFFF, `RESP_OKAY);
        rd(`REG_CMP_A, {16'h0, top}, 32'hFFFFFFFF, `RESP_OKAY);
      end
      measure(top, per, at_top, hi_a, hi_b);
      check("period", 32'(2 * top), per);
      check("top hold", 32'h1, at_top);
    end
    // Every prescale factor with a TOP of three
    for (int i = 0; i < 5; i++)
    begin
      wr(`REG_CTRL, 32'h0, `RESP_OKAY);
      wr(`REG_CAPT, 32'h3, `RESP_OKAY);
      wr(`REG_COUNT, 32'h0, `RESP_OKAY);
      wr(`REG_CTRL, cw(`WGM_PC_CAPT, 2'h0, 2'h0, 3'(i + 1), 1'b0),
        `RESP_OKAY);
      measure(16'h0003, per, at_top, hi_a, hi_b);
      check("tick period", 32'(6 * divs[i]), per);
      check("tick top", 32'(divs[i]), at_top);
    end
    // Duty at bottom, a random middle value and TOP, both polarities
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      c = (i == 0) ? 16'h0 : (i == 1) ? {13'h0, rnd[2:0]} | 16'h1 : 16'h8;
      wr(`REG_CTRL, 32'h0, `RESP_OKAY);
      wr(`REG_FLAGS, 32'hF, `RESP_OKAY);
      wr(`REG_COUNT, 32'h0, `RESP_OKAY);
      wr(`REG_CAPT, 32'h8, `RESP_OKAY);
      wr(`REG_CMP_A, {16'h0, c}, `RESP_OKAY);
      wr(`REG_CMP_B, {16'h0, c}, `RESP_OKAY);
      wr(`REG_CTRL, cw(`WGM_PFC_CAPT, `OSEL_NONINV, `OSEL_INV, `CS_DIV8,
        1'b1), `RESP_OKAY);
      measure(16'h0008, per, at_top, hi_a, hi_b);
      measure(16'h0008, per, at_top, hi_a, hi_b);
      check("duty a", 32'(16 * c), hi_a);
      check("duty b", 32'(128 - 16 * c), hi_b);
      check("pin b", 32'h0, {31'h0, pin_b});
      wr(`REG_CTRL, cw(`WGM_PFC_CAPT, `OSEL_NONINV, `OSEL_INV, `CS_STOP,
        1'b1), `RESP_OKAY);
      rd(`REG_FLAGS, 32'hF, 32'hF, `RESP_OKAY);
      wr(`REG_FLAGS, 32'hF, `RESP_OKAY);
      rd(`REG_FLAGS, 32'h0, 32'hF, `RESP_OKAY);
      wr(`REG_CMP_A, 32'h3, `RESP_OKAY);
      wr(`REG_ACT_A, 32'h5, `RESP_OKAY);
      rd(`REG_ACT_A, {16'h0, c}, 32'hFFFFFFFF, `RESP_OKAY);
    end
    end_sim();
  end
endmodule : dual_slope_pwm_timer16_tb

`default_nettype wire

// ### tb/pin_load.sv
// Load on the compare output pins, pulled low when undriven
`timescale 1ns/1ps
`default_nettype none

module pin_load
(
  input wire pwm_timer_pkg::pwm_pins_t pins,
  output logic pin_a,
  output logic pin_b
);
  import pwm_timer_pkg::*;

  // Pull-down wins while the timer leaves a pin undriven
  assign pin_a = pins.oe[0] ? pins.level[0] : 1'b0;
  assign pin_b = pins.oe[1] ? pins.level[1] : 1'b0;
endmodule : pin_load

`default_nettype wire
